// ### usm_afe_model.sv
// usm_afe_model: analog side stand-in for drive supply and drive pulses
`timescale 1ns/10ps
`default_nettype none
module usm_afe_model (
  input wire logic i_mclk,
  input wire logic i_regulator_on,
  input wire logic i_tx_active,
  input wire logic [7:0] i_dly,
  output logic o_supply_at_target,
  output logic o_pulse_sent
);
  logic [7:0] ramp_r;
  logic [1:0] gap_r;
  // supply settles i_dly cycles after regulation starts
  always_ff @(posedge i_mclk) begin
    if (!i_regulator_on) ramp_r <= 8'h00;
    else if (ramp_r != 8'hff) ramp_r <= ramp_r + 8'h01;
  end
  assign o_supply_at_target = i_regulator_on && (ramp_r >= i_dly);
  // one drive pulse every fourth burst cycle
  always_ff @(posedge i_mclk) begin
    if (!i_tx_active) gap_r <= 2'h0;
    else gap_r <= gap_r + 2'h1;
  end
  assign o_pulse_sent = i_tx_active && (gap_r == 2'h3);
endmodule // usm_afe_model
`default_nettype wire

// ### usm_counter.sv
// usm_counter: saturating event counter with terminal flag
`timescale 1ns/10ps
`default_nettype none
module usm_counter #(
  parameter int W = 8
) (
  input wire logic i_mclk,
  input wire logic i_rst_b,
  input wire logic i_clr,
  input wire logic i_inc,
  input wire logic [W-1:0] i_limit,
  output logic o_done
);
  // ----------------------------------------------------------------
  // parameter check
  // ----------------------------------------------------------------
  if (W < 1 || W > 31) begin : g_bad_w
    $error("usm_counter: width out of range");
  end

  logic [W-1:0] cnt_r;

  // terminal reached once the count meets the limit
  assign o_done = (cnt_r >= i_limit);

  // count up, hold at limit, restart on clear
  always_ff @(posedge i_mclk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      cnt_r <= '0;
    end else if (i_clr) begin
      cnt_r <= '0;
    end else if (i_inc && !o_done) begin
      cnt_r <= cnt_r + {{(W-1){1'b0}}, 1'b1};
    end
  end
endmodule // usm_counter
`default_nettype wire

// ### usm_ctrl.sv
// usm_ctrl: operating-mode sequencer and receive-path configuration registers
// Contract
// - trim override set: effective filter code is frequency code plus signed trim
// - trim 0x8..0xF goes below code 0x00, 0x1..0x7 above code 0x2F
// - highpass conversion: corner follows frequency code, quality and trim ignored
// - first and last gain stages are switched off independently
// - 4-bit intercept code: 0x0/0x8 unity, 0x1-0x7 raise, 0x9-0xF lower
// - range select chooses output range, gain adjust sets gain within it
// - echo interrupt follows envelope above threshold, falls without the clock
// - effective echo threshold uses threshold select and range select together
// - zero-cross output off after reset until the enable bit is set
// - when enabled, stage select and hysteresis drive the comparator
// - echo gate set: zero-cross toggles pass only while echo interrupt high
// - sleep: all blocks and regulation off, register port stays live
// - after sleep exit, stay put until drive supply reaches target
// - standby: regulation on, other analog off, entered by standby request
// - neither sleep nor standby: listen, transmitter idle, receiver on
// - burst command enters burst, end of burst returns to listen
// - from reset or sleep, leave wait on supply at target or 64 ms
// - regulation disabled: leave wait at once
// - burst started by command, ended after programmed pulse count
// - mode code: 00 listen, 01 burst, 10 standby, 11 sleep
// - supply ready flag set once regulator reaches target
`timescale 1ns/10ps
`default_nettype none
module usm_ctrl
  import usm_pkg::*;
#(
  parameter int WAIT_CYC = SUPPLY_WAIT_CYC
) (
  input wire logic i_mclk,
  input wire logic i_rst_b,
  // register port
  input wire logic [5:0] i_addr,
  input wire logic [7:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  output logic [7:0] o_rdata,
  // analog status
  input wire logic i_supply_at_target,
  input wire logic i_env_above_thr,
  input wire logic i_zc_raw,
  input wire logic i_pulse_sent,
  // filter controls
  output logic [6:0] o_filter_code,
  output logic o_highpass_conversion,
  output logic [1:0] o_filter_quality_select,
  // amplifier and output controls
  output logic o_first_gain_stage_off,
  output logic o_last_gain_stage_off,
  output logic [3:0] o_intercept_adjust_code,
  output logic o_intercept_raise,
  output logic o_intercept_lower,
  output logic o_output_range_select,
  output logic [2:0] o_output_gain_adjust,
  output logic [4:0] o_echo_thr_code,
  output logic [1:0] o_zero_cross_stage_select,
  output logic [1:0] o_zero_cross_hysteresis,
  output logic [3:0] o_drive_supply_target,
  // power and mode
  output logic o_regulator_on,
  output logic o_rx_active,
  output logic o_tx_active,
  output logic [1:0] o_mode_state_code,
  output logic o_supply_ready_flag,
  // pins
  output logic o_echo_interrupt_pin,
  output logic o_zero_cross_pin
);
  // ----------------------------------------------------------------
  // parameter check
  // ----------------------------------------------------------------
  if (WAIT_CYC < 1 || WAIT_CYC >= (1 << WAIT_CNT_W)) begin : g_bad_wait
    $error("usm_ctrl: wait count does not fit the timer");
  end

  // ----------------------------------------------------------------
  // configuration registers
  // ----------------------------------------------------------------
  logic [7:0] filt_cfg1_r;
  logic [7:0] filt_cfg2_r;
  logic [7:0] amp_ctrl1_r;
  logic [7:0] amp_ctrl2_r;
  logic [7:0] mode_ctrl_r;
  logic [7:0] supply_ctrl_r;
  logic [7:0] echo_cfg_r;
  logic [7:0] zc_cfg_r;
  logic [7:0] burst_cfg_r;
  logic burst_cmd;
  logic sleep_req;
  logic stdby_req;
  logic sup_en;

  // register writes
  always_ff @(posedge i_mclk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      filt_cfg1_r <= RST_FILT_CFG1;
      filt_cfg2_r <= RST_FILT_CFG2;
      amp_ctrl1_r <= RST_AMP_CTRL1;
      amp_ctrl2_r <= RST_AMP_CTRL2;
      mode_ctrl_r <= RST_MODE_CTRL;
      supply_ctrl_r <= RST_SUPPLY_CTRL;
      echo_cfg_r <= RST_ECHO_CFG;
      zc_cfg_r <= RST_ZC_CFG;
      burst_cfg_r <= RST_BURST_CFG;
    end else if (i_wr) begin
      case (i_addr)
        ADDR_FILT_CFG1: filt_cfg1_r <= i_wdata;
        ADDR_FILT_CFG2: filt_cfg2_r <= {2'h0, i_wdata[5:0]};
        ADDR_AMP_CTRL1: amp_ctrl1_r <= i_wdata;
        ADDR_AMP_CTRL2: amp_ctrl2_r <= {6'h00, i_wdata[1:0]};
        // burst command bit is not stored
        ADDR_MODE_CTRL: mode_ctrl_r <= {5'h00, i_wdata[2:1], 1'b0};
        ADDR_SUPPLY_CTRL: supply_ctrl_r <= {3'h0, i_wdata[4:0]};
        ADDR_ECHO_CFG: echo_cfg_r <= {4'h0, i_wdata[3:0]};
        ADDR_ZC_CFG: zc_cfg_r <= {i_wdata[7:2], 2'h0};
        ADDR_BURST_CFG: burst_cfg_r <= {2'h0, i_wdata[5:0]};
        default: ;
      endcase
    end
  end

  assign burst_cmd = i_wr && (i_addr == ADDR_MODE_CTRL) && i_wdata[F_BURST_GO];
  assign sleep_req = mode_ctrl_r[F_SLEEP_REQ];
  assign stdby_req = mode_ctrl_r[F_STDBY_REQ];
  assign sup_en = supply_ctrl_r[F_SUP_EN];

  // ----------------------------------------------------------------
  // mode sequencer
  // ----------------------------------------------------------------
  usm_state_e state_r;
  usm_state_e state_nxt;
  logic wait_done;
  logic burst_done;
  logic sup_ok;

  // restarts on every entry to wait
  usm_counter #(.W(WAIT_CNT_W)) u_wait_timer (
    .i_mclk(i_mclk),
    .i_rst_b(i_rst_b),
    .i_clr(state_r != USM_ST_WAIT),
    .i_inc(state_r == USM_ST_WAIT),
    .i_limit(WAIT_CNT_W'(WAIT_CYC)),
    .o_done(wait_done)
  );

  usm_counter #(.W(6)) u_pulse_cnt (
    .i_mclk(i_mclk),
    .i_rst_b(i_rst_b),
    .i_clr(state_r != USM_ST_BURST),
    .i_inc(i_pulse_sent),
    .i_limit(burst_cfg_r[5:0]),
    .o_done(burst_done)
  );

  // no supply wait when regulation is off
  assign sup_ok = !sup_en || i_supply_at_target || wait_done;

  // next mode
  always_comb begin
    state_nxt = state_r;
    case (state_r)
      // hold until the supply is good
      USM_ST_WAIT: begin
        if (sleep_req) begin
          state_nxt = USM_ST_SLEEP;
        end else if (sup_ok) begin
          state_nxt = stdby_req ? USM_ST_STANDBY : USM_ST_LISTEN;
        end
      end
      // leave sleep by clearing the request
      USM_ST_SLEEP: begin
        if (!sleep_req) begin
          state_nxt = USM_ST_WAIT;
        end
      end
      USM_ST_STANDBY: begin
        if (sleep_req) begin
          state_nxt = USM_ST_SLEEP;
        end else if (!stdby_req) begin
          state_nxt = USM_ST_LISTEN;
        end
      end
      USM_ST_LISTEN: begin
        if (sleep_req) begin
          state_nxt = USM_ST_SLEEP;
        end else if (stdby_req) begin
          state_nxt = USM_ST_STANDBY;
        end else if (burst_cmd) begin
          state_nxt = USM_ST_BURST;
        end
      end
      // end of burst returns to listen
      USM_ST_BURST: begin
        if (sleep_req) begin
          state_nxt = USM_ST_SLEEP;
        end else if (stdby_req) begin
          state_nxt = USM_ST_STANDBY;
        end else if (burst_done) begin
          state_nxt = USM_ST_LISTEN;
        end
      end
      default: state_nxt = USM_ST_WAIT;
    endcase
  end

  // mode register
  always_ff @(posedge i_mclk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      state_r <= USM_ST_WAIT;
    end else begin
      state_r <= state_nxt;
    end
  end

  // ----------------------------------------------------------------
  // power enables and status
  // ----------------------------------------------------------------
  logic [1:0] code_nxt;
  logic sup_rdy_r;

  // mode code, wait reports as sleep
  // taken from the next state so code and enables change on the same edge as the mode
  always_comb begin
    case (state_nxt)
      USM_ST_LISTEN: code_nxt = CODE_LISTEN;
      USM_ST_BURST: code_nxt = CODE_BURST;
      USM_ST_STANDBY: code_nxt = CODE_STANDBY;
      default: code_nxt = CODE_SLEEP;
    endcase
  end

  always_ff @(posedge i_mclk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_regulator_on <= 1'b0;
      o_rx_active <= 1'b0;
      o_tx_active <= 1'b0;
      o_mode_state_code <= CODE_SLEEP;
    end else begin
      o_regulator_on <= sup_en && (state_nxt != USM_ST_SLEEP);
      o_rx_active <= (state_nxt == USM_ST_LISTEN) || (state_nxt == USM_ST_BURST);
      o_tx_active <= (state_nxt == USM_ST_BURST);
      o_mode_state_code <= code_nxt;
    end
  end

  always_ff @(posedge i_mclk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      sup_rdy_r <= 1'b0;
    end else if (!o_regulator_on) begin
      sup_rdy_r <= 1'b0;
    end else if (i_supply_at_target) begin
      sup_rdy_r <= 1'b1;
    end
  end
  assign o_supply_ready_flag = sup_rdy_r;

  // ----------------------------------------------------------------
  // receive path configuration
  // ----------------------------------------------------------------
  logic [6:0] filt_code_nxt;
  logic bypass;

  assign bypass = filt_cfg1_r[F_HIGHPASS];

  // signed trim on top of the frequency code
  always_comb begin
    if (filt_cfg1_r[F_TRIM_OVR] && !bypass) begin
      filt_code_nxt = {1'b0, filt_cfg1_r[5:0]} + {{3{filt_cfg2_r[3]}}, filt_cfg2_r[3:0]};
    end else begin
      filt_code_nxt = {1'b0, filt_cfg1_r[5:0]};
    end
  end

  // registered analog control words
  always_ff @(posedge i_mclk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_filter_code <= 7'h00;
      o_highpass_conversion <= 1'b0;
      o_filter_quality_select <= 2'h0;
      o_intercept_raise <= 1'b0;
      o_intercept_lower <= 1'b0;
      o_echo_thr_code <= 5'h00;
    end else begin
      o_filter_code <= filt_code_nxt;
      o_highpass_conversion <= bypass;
      o_filter_quality_select <= bypass ? 2'h0 : filt_cfg2_r[F_Q_LSB +: 2];
      o_intercept_raise <= !amp_ctrl1_r[3] && (amp_ctrl1_r[2:0] != 3'h0);
      o_intercept_lower <= amp_ctrl1_r[3] && (amp_ctrl1_r[2:0] != 3'h0);
      o_echo_thr_code <= {amp_ctrl1_r[F_RANGE_SEL], echo_cfg_r[3:0]};
    end
  end

  assign o_first_gain_stage_off = amp_ctrl2_r[F_FIRST_OFF];
  assign o_last_gain_stage_off = amp_ctrl2_r[F_LAST_OFF];
  assign o_intercept_adjust_code = amp_ctrl1_r[3:0];
  assign o_output_range_select = amp_ctrl1_r[F_RANGE_SEL];
  assign o_output_gain_adjust = amp_ctrl1_r[F_GAIN_LSB +: 3];
  assign o_zero_cross_stage_select = zc_cfg_r[F_ZC_STG_LSB +: 2];
  assign o_zero_cross_hysteresis = zc_cfg_r[F_ZC_HYS_LSB +: 2];
  assign o_drive_supply_target = supply_ctrl_r[3:0];

  // ----------------------------------------------------------------
  // echo and zero-cross pins
  // ----------------------------------------------------------------
  // combinational, falls with the comparator
  assign o_echo_interrupt_pin = o_rx_active && i_env_above_thr;
  assign o_zero_cross_pin = zc_cfg_r[F_ZC_EN] && o_rx_active && i_zc_raw &&
                            (!zc_cfg_r[F_ZC_GATE] || o_echo_interrupt_pin);

  // ----------------------------------------------------------------
  // register read, data one cycle after the strobe
  // ----------------------------------------------------------------
  always_ff @(posedge i_mclk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_rdata <= 8'h00;
    end else if (i_rd) begin
      case (i_addr)
        ADDR_FILT_CFG1: o_rdata <= filt_cfg1_r;
        ADDR_FILT_CFG2: o_rdata <= filt_cfg2_r;
        ADDR_AMP_CTRL1: o_rdata <= amp_ctrl1_r;
        ADDR_AMP_CTRL2: o_rdata <= amp_ctrl2_r;
        ADDR_MODE_CTRL: o_rdata <= mode_ctrl_r;
        ADDR_SUPPLY_CTRL: o_rdata <= supply_ctrl_r;
        ADDR_ECHO_CFG: o_rdata <= echo_cfg_r;
        ADDR_ZC_CFG: o_rdata <= zc_cfg_r;
        ADDR_BURST_CFG: o_rdata <= burst_cfg_r;
        ADDR_STATUS: o_rdata <= {2'h0, sup_rdy_r, 3'h0, o_mode_state_code};
        default: o_rdata <= 8'h00;
      endcase
    end else begin
      o_rdata <= 8'h00;
    end
  end

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  sequence s_listen_cmd;
    state_r == USM_ST_LISTEN && burst_cmd && !sleep_req && !stdby_req;
  endsequence
  // enables are registered from the next state, so they rise with the mode
  sequence s_in_burst;
    state_r == USM_ST_BURST && o_tx_active && o_rx_active;
  endsequence

  property p_burst_entry;
    @(posedge i_mclk) disable iff (!i_rst_b) s_listen_cmd |=> s_in_burst;
  endproperty
  a_burst_entry: assert property (p_burst_entry) else $error("burst not entered");

  property p_wait_hold;
    @(posedge i_mclk) disable iff (!i_rst_b)
      state_r == USM_ST_WAIT && sup_en && !i_supply_at_target && !wait_done && !sleep_req
      |=> state_r == USM_ST_WAIT && o_mode_state_code == CODE_SLEEP;
  endproperty
  a_wait_hold: assert property (p_wait_hold) else $error("left wait too early");

  property p_no_reg;
    @(posedge i_mclk) disable iff (!i_rst_b)
      state_r == USM_ST_WAIT && !sup_en && !sleep_req |=> state_r != USM_ST_WAIT;
  endproperty
  a_no_reg: assert property (p_no_reg) else $error("wait without regulation");

  property p_sleep_off;
    @(posedge i_mclk) disable iff (!i_rst_b)
      state_r == USM_ST_SLEEP && $past(state_r) == USM_ST_SLEEP
      |-> !o_regulator_on && !o_rx_active && !o_tx_active && o_mode_state_code == CODE_SLEEP;
  endproperty
  a_sleep_off: assert property (p_sleep_off) else $error("block on in sleep");

  property p_sleep_first;
    @(posedge i_mclk) disable iff (!i_rst_b)
      sleep_req && stdby_req && state_r == USM_ST_STANDBY |=> state_r == USM_ST_SLEEP;
  endproperty
  a_sleep_first: assert property (p_sleep_first) else $error("standby beat sleep");

  property p_standby_code;
    @(posedge i_mclk) disable iff (!i_rst_b)
      state_r == USM_ST_STANDBY && !sleep_req && stdby_req
      |=> o_mode_state_code == CODE_STANDBY && !o_rx_active && o_regulator_on == $past(sup_en);
  endproperty
  a_standby_code: assert property (p_standby_code) else $error("standby outputs wrong");

  property p_trim_zero;
    @(posedge i_mclk) disable iff (!i_rst_b)
      filt_cfg1_r[F_TRIM_OVR] && filt_cfg2_r[3] && !bypass
      |=> o_filter_code != {1'b0, $past(filt_cfg1_r[5:0])};
  endproperty
  a_trim_zero: assert property (p_trim_zero) else $error("negative trim not applied");

  property p_zc_off;
    @(posedge i_mclk) disable iff (!i_rst_b) !zc_cfg_r[F_ZC_EN] |-> !o_zero_cross_pin;
  endproperty
  a_zc_off: assert property (p_zc_off) else $error("zero cross while disabled");

  property p_zc_gate;
    @(posedge i_mclk) disable iff (!i_rst_b)
      zc_cfg_r[F_ZC_GATE] && !i_env_above_thr |-> !o_zero_cross_pin;
  endproperty
  a_zc_gate: assert property (p_zc_gate) else $error("zero cross not gated");

  property p_burst_end;
    @(posedge i_mclk) disable iff (!i_rst_b)
      state_r == USM_ST_BURST && burst_done && !sleep_req && !stdby_req
      |=> state_r == USM_ST_LISTEN && !o_tx_active;
  endproperty
  a_burst_end: assert property (p_burst_end) else $error("burst did not end");
endmodule // usm_ctrl
`default_nettype wire

// ### usm_pkg.sv
// usm_pkg: constants, register map and mode encoding of the ultrasonic mode/rx config block
package usm_pkg;
  // ----------------------------------------------------------------
  // register addresses
  // ----------------------------------------------------------------
  localparam logic [5:0] ADDR_FILT_CFG1 = 6'h10;
  localparam logic [5:0] ADDR_FILT_CFG2 = 6'h11;
  localparam logic [5:0] ADDR_AMP_CTRL1 = 6'h12;
  localparam logic [5:0] ADDR_AMP_CTRL2 = 6'h13;
  localparam logic [5:0] ADDR_MODE_CTRL = 6'h14;
  localparam logic [5:0] ADDR_SUPPLY_CTRL = 6'h16;
  localparam logic [5:0] ADDR_ECHO_CFG = 6'h17;
  localparam logic [5:0] ADDR_ZC_CFG = 6'h18;
  localparam logic [5:0] ADDR_BURST_CFG = 6'h1a;
  localparam logic [5:0] ADDR_STATUS = 6'h1c;
  // ----------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------
  localparam int F_TRIM_OVR = 7;     // filt_cfg1
  localparam int F_HIGHPASS = 6;     // filt_cfg1, freq code in [5:0]
  localparam int F_Q_LSB = 4;        // filt_cfg2 [5:4], trim in [3:0]
  localparam int F_RANGE_SEL = 7;    // amp_ctrl1
  localparam int F_GAIN_LSB = 4;     // amp_ctrl1 [6:4], intercept in [3:0]
  localparam int F_FIRST_OFF = 1;    // amp_ctrl2
  localparam int F_LAST_OFF = 0;     // amp_ctrl2
  localparam int F_SLEEP_REQ = 2;    // mode_ctrl
  localparam int F_STDBY_REQ = 1;    // mode_ctrl
  localparam int F_BURST_GO = 0;     // mode_ctrl, write-one command
  localparam int F_SUP_EN = 4;       // supply_ctrl, target in [3:0]
  localparam int F_ZC_EN = 7;        // zc_cfg
  localparam int F_ZC_GATE = 6;      // zc_cfg
  localparam int F_ZC_STG_LSB = 4;   // zc_cfg [5:4]
  localparam int F_ZC_HYS_LSB = 2;   // zc_cfg [3:2]
  localparam int F_SUP_RDY = 5;      // status, mode code in [1:0]
  // ----------------------------------------------------------------
  // reset values
  // ----------------------------------------------------------------
  localparam logic [7:0] RST_FILT_CFG1 = 8'h00;
  localparam logic [7:0] RST_FILT_CFG2 = 8'h00;
  localparam logic [7:0] RST_AMP_CTRL1 = 8'h00;
  localparam logic [7:0] RST_AMP_CTRL2 = 8'h00;
  localparam logic [7:0] RST_MODE_CTRL = 8'h00;
  localparam logic [7:0] RST_SUPPLY_CTRL = 8'h10;
  localparam logic [7:0] RST_ECHO_CFG = 8'h00;
  localparam logic [7:0] RST_ZC_CFG = 8'h00;
  localparam logic [7:0] RST_BURST_CFG = 8'h01;
  // ----------------------------------------------------------------
  // mode codes and timing
  // ----------------------------------------------------------------
  localparam logic [1:0] CODE_LISTEN = 2'h0;
  localparam logic [1:0] CODE_BURST = 2'h1;
  localparam logic [1:0] CODE_STANDBY = 2'h2;
  localparam logic [1:0] CODE_SLEEP = 2'h3;
  localparam int CLK_KHZ = 40000;
  localparam int SUPPLY_WAIT_US = 64000;
  localparam int SUPPLY_WAIT_CYC = (SUPPLY_WAIT_US / 1000) * CLK_KHZ;
  localparam int WAIT_CNT_W = 22;
  // operating mode, one-hot
  typedef enum logic [5:0] {
    USM_ST_WAIT    = 6'h01,
    USM_ST_SLEEP   = 6'h02,
    USM_ST_STANDBY = 6'h04,
    USM_ST_LISTEN  = 6'h08,
    USM_ST_BURST   = 6'h10,
    USM_ST_SPARE   = 6'h20
  } usm_state_e;
endpackage

// ### usm_tb.sv
// tb: register-level checks of the mode sequencer and receive configuration
`timescale 1ns/10ps
`default_nettype none
module tb;
  import usm_pkg::*;
  logic i_mclk, i_rst_b, i_wr, i_rd, env, zc, sup, pls, hp, rse, rlo, rsel, reg_on, rx, tx, rdy;
  logic echo, zcp, f_off, l_off;
  logic [3:0] icode, tgt;
  logic [5:0] i_addr;
  logic [7:0] i_wdata, o_rdata, dly, rd;
  logic [6:0] fcode;
  logic [1:0] qsel, mode, stg, hys;
  logic [2:0] gain;
  logic [4:0] thr;
  int error_cnt = 0;
  int total_checks = 0;
  usm_ctrl #(.WAIT_CYC(20)) dut (.i_mclk(i_mclk), .i_rst_b(i_rst_b), .i_addr(i_addr),
    .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .i_supply_at_target(sup),
    .i_env_above_thr(env), .i_zc_raw(zc), .i_pulse_sent(pls), .o_filter_code(fcode),
    .o_highpass_conversion(hp), .o_filter_quality_select(qsel), .o_first_gain_stage_off(f_off),
    .o_last_gain_stage_off(l_off), .o_intercept_adjust_code(icode), .o_intercept_raise(rse),
    .o_intercept_lower(rlo), .o_output_range_select(rsel), .o_output_gain_adjust(gain),
    .o_echo_thr_code(thr), .o_zero_cross_stage_select(stg), .o_zero_cross_hysteresis(hys),
    .o_drive_supply_target(tgt), .o_regulator_on(reg_on), .o_rx_active(rx), .o_tx_active(tx),
    .o_mode_state_code(mode), .o_supply_ready_flag(rdy), .o_echo_interrupt_pin(echo),
    .o_zero_cross_pin(zcp));
  usm_afe_model afe (.i_mclk(i_mclk), .i_regulator_on(reg_on), .i_tx_active(tx), .i_dly(dly),
    .o_supply_at_target(sup), .o_pulse_sent(pls));
  // clock generator
  initial begin
    i_mclk = 1'b0;
    forever #12.5 i_mclk = ~i_mclk;
  end
  // ----------------------------------------------------------------
  // access tasks
  // ----------------------------------------------------------------
  task automatic chk(input string nm, input logic [7:0] exp, input logic [7:0] got);
    total_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("unexpected %s: expected %h, seen %h", nm, exp, got);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge i_mclk);
    #1;
  endtask
  task automatic wr(input logic [5:0] a, input logic [7:0] d);
    @(posedge i_mclk);
    i_wr <= 1'b1;
    i_addr <= a;
    i_wdata <= d;
    @(posedge i_mclk);
    i_wr <= 1'b0;
  endtask
  // read data stand only in the cycle after the strobe edge
  task automatic rdr(input logic [5:0] a);
    @(posedge i_mclk);
    i_rd <= 1'b1;
    i_addr <= a;
    @(posedge i_mclk);
    i_rd <= 1'b0;
    #1;
    rd = o_rdata;
  endtask
  task automatic wait_mode(input logic [1:0] m, input int lim);
    int n;
    n = 0;
    while (mode !== m && n < lim) begin
      tick(1);
      n++;
    end
    chk("mode", {6'h0, m}, {6'h0, mode});
  endtask
  task automatic print_verdict();
    $display("checks %0d, mismatches %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  // watchdog against a hung sequence
  initial begin
    repeat (3000) @(posedge i_mclk);
    error_cnt++;
    print_verdict();
  end
  // ----------------------------------------------------------------
  // test sequence
  // ----------------------------------------------------------------
  initial begin
    i_rst_b = 1'b0;
    i_wr = 1'b0;
    i_rd = 1'b0;
    i_addr = 6'h00;
    i_wdata = 8'h00;
    env = 1'b0;
    zc = 1'b1;
    dly = 8'd40;
    repeat (12) @(posedge i_mclk);
    chk("reset mode", 8'h03, {6'h0, mode});
    i_rst_b <= 1'b1;
    tick(10);
    chk("mode in wait", 8'h03, {6'h0, mode});
    wait_mode(CODE_LISTEN, 20);
    chk("rx tx", 8'h01, {6'h0, tx, rx});
    tick(30);
    rdr(ADDR_STATUS);
    chk("status", 8'h20, rd);
    chk("ready", 8'h01, {7'h0, rdy});
    rdr(6'h3f);
    chk("unmapped", 8'h00, rd);
    $display("test power-up done");
    wr(ADDR_FILT_CFG1, 8'h85);
    wr(ADDR_FILT_CFG2, 8'h38);
    tick(2);
    chk("code below", 8'h7d, {1'b0, fcode});
    wr(ADDR_FILT_CFG1, 8'haf);
    wr(ADDR_FILT_CFG2, 8'h37);
    tick(2);
    chk("code above", 8'h36, {1'b0, fcode});
    wr(ADDR_FILT_CFG1, 8'hef);
    tick(2);
    chk("highpass", 8'haf, {hp, fcode});
    chk("quality", 8'h00, {6'h0, qsel});
    for (int c = 0; c < 16; c++) begin
      wr(ADDR_AMP_CTRL1, 8'(c));
      tick(2);
      chk("intercept", {6'h0, c > 8, c > 0 && c < 8}, {6'h0, rlo, rse});
      chk("intercept code", 8'(c), {4'h0, icode});
    end
    for (int c = 0; c < 4; c++) begin
      wr(ADDR_AMP_CTRL2, 8'(c));
      tick(2);
      chk("stages off", 8'(c), {6'h0, f_off, l_off});
    end
    wr(ADDR_AMP_CTRL1, 8'ha0);
    wr(ADDR_ECHO_CFG, 8'h05);
    tick(2);
    chk("range gain", 8'h0a, {4'h0, rsel, gain});
    chk("threshold", 8'h15, {3'h0, thr});
    $display("test configuration done");
    wr(ADDR_BURST_CFG, 8'h03);
    wr(ADDR_MODE_CTRL, 8'h01);
    wait_mode(CODE_BURST, 3);
    chk("tx burst", 8'h03, {6'h0, tx, rx});
    tick(5);
    chk("still burst", 8'h01, {6'h0, mode});
    wait_mode(CODE_LISTEN, 16);
    wr(ADDR_MODE_CTRL, 8'h02);
    wait_mode(CODE_STANDBY, 3);
    chk("standby power", 8'h02, {6'h0, reg_on, rx});
    wr(ADDR_MODE_CTRL, 8'h03);
    tick(3);
    chk("burst refused", 8'h02, {6'h0, mode});
    wr(ADDR_MODE_CTRL, 8'h06);
    wait_mode(CODE_SLEEP, 3);
    chk("sleep power", 8'h00, {6'h0, reg_on, rx});
    rdr(ADDR_MODE_CTRL);
    chk("port in sleep", 8'h06, rd);
    chk("ready in sleep", 8'h00, {7'h0, rdy});
    dly = 8'd6;
    wr(ADDR_MODE_CTRL, 8'h00);
    tick(4);
    chk("held for supply", 8'h03, {6'h0, mode});
    wait_mode(CODE_LISTEN, 8);
    wr(ADDR_SUPPLY_CTRL, 8'h0a);
    wr(ADDR_MODE_CTRL, 8'h04);
    wait_mode(CODE_SLEEP, 3);
    chk("target", 8'h0a, {4'h0, tgt});
    wr(ADDR_MODE_CTRL, 8'h00);
    wait_mode(CODE_LISTEN, 3);
    $display("test modes done");
    chk("zc off", 8'h00, {7'h0, zcp});
    wr(ADDR_ZC_CFG, 8'hbc); // high stage for a weak echo
    tick(2);
    chk("zc on", 8'h1f, {3'h0, zcp, stg, hys});
    wr(ADDR_ZC_CFG, 8'hc0);
    tick(2);
    chk("zc gated", 8'h00, {6'h0, echo, zcp});
    @(posedge i_mclk);
    env <= 1'b1;
    #1;
    chk("zc echo", 8'h03, {6'h0, echo, zcp});
    @(posedge i_mclk);
    env <= 1'b0;
    #1;
    chk("echo fall", 8'h00, {6'h0, echo, zcp});
    $display("test zero-cross done");
    print_verdict();
  end
endmodule // tb
`default_nettype wire
